// ===== logic/sfcs_consts.svh
// register offsets, field positions, reset values and codes of the flash capture/stats block
`ifndef SFCS_CONSTS_SVH
`define SFCS_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SFCS_OFF_MODE      8'h00
`define SFCS_OFF_CAPT      8'h04
`define SFCS_OFF_STATUS    8'h08
`define SFCS_OFF_AUX       8'h0c
`define SFCS_OFF_HIT       8'h10
`define SFCS_OFF_MISS      8'h14
`define SFCS_OFF_SHIFT     8'h18
`define SFCS_OFF_TARGET    8'h1c
`define SFCS_OFF_IRQ_MASK  8'h30

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SFCS_POS_CMD_LO    0
`define SFCS_POS_CMD_HI    3
`define SFCS_POS_POL       14
`define SFCS_POS_PHA       15
`define SFCS_POS_CAPT      4
`define SFCS_POS_EXIT      0
`define SFCS_POS_HIT_EN    0
`define SFCS_POS_MISS_EN   1
`define SFCS_POS_MATCH_EN  2
`define SFCS_POS_OFS_EN    3

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define SFCS_RST_CMD       4'h5
`define SFCS_RST_POL       1'b0
`define SFCS_RST_PHA       1'b0
`define SFCS_RST_CAPT      1'b1
`define SFCS_RST_WORD      32'h0000_0000
`define SFCS_CMD_EXIT_A    4'hc
`define SFCS_CMD_EXIT_B    4'hd
`define SFCS_RESP_OKAY     2'h0
`define SFCS_RESP_SLVERR   2'h2

`endif

// ===== logic/sfcs_pkg.sv
// shared types of the flash capture/stats block
package sfcs_pkg;

  // serial link configuration seen by the capture logic
  typedef struct packed {
    logic pol;
    logic pha;
    logic capt_edge;
  } sfcs_link_cfg_t;

  // one cache lookup reported by the cache
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] addr;
  } sfcs_lookup_t;

  // one flash access address to be shifted
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } sfcs_access_t;

endpackage

// ===== logic/sfcs_capture.sv
// serial clock edge finder and read data capture
module sfcs_capture (
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire logic                    clk_en,
  input  wire sfcs_pkg::sfcs_link_cfg_t cfg,
  input  wire logic                    sclk_raw,
  input  wire logic                    sdi_raw,
  output logic                         cap_pulse,
  output logic                         cap_bit_ff
);
  import sfcs_pkg::*;

  logic sclk_s1_ff;
  logic sclk_s2_ff;
  logic sclk_s3_ff;
  logic sdi_s1_ff;
  logic sdi_s2_ff;
  logic rise;
  logic fall;
  logic use_rise;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // first stage feeds only the second; edges are judged on stages 2/3
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      sdi_s1_ff  <= 1'b0;
      sdi_s2_ff  <= 1'b0;
    end else if (clk_en) begin
      sclk_s1_ff <= sclk_raw;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      sdi_s1_ff  <= sdi_raw;
      sdi_s2_ff  <= sdi_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // edge choice
  // ----------------------------------------------------------------
  // select 0: rising when polarity equals phase; select 1 with phase 0
  // moves to the opposite edge for extra time; phase 1 keeps select-0 edges
  assign rise     = sclk_s2_ff & ~sclk_s3_ff;
  assign fall     = ~sclk_s2_ff & sclk_s3_ff;
  assign use_rise = (cfg.pol ~^ cfg.pha) ^ (cfg.capt_edge & ~cfg.pha);
  assign cap_pulse = clk_en & (use_rise ? rise : fall);

  // data travels the same two stages as the clock, so it is aligned
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_bit_ff <= 1'b0;
    end else if (cap_pulse) begin
      cap_bit_ff <= sdi_s2_ff;
    end
  end

endmodule // sfcs_capture

// ===== logic/sfcs_top.sv
// flash capture edge, exit flag, cache tallies and address shift with axi4-lite registers
`include "sfcs_consts.svh"

module sfcs_top #(
  parameter int AW = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  // axi4-lite slave
  input  wire logic [AW-1:0]         s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AW-1:0]         s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // serial link
  input  wire logic                  sclk_in,
  input  wire logic                  sdi_in,
  output logic                       sclk_idle_lvl_ff,
  output logic                       cap_pulse,
  output logic                       cap_bit_ff,
  // transfer engine and cache
  input  wire logic                  xfer_done,
  input  wire sfcs_pkg::sfcs_lookup_t lookup,
  input  wire sfcs_pkg::sfcs_access_t access,
  output logic [3:0]                 cmd_type_ff,
  output logic                       flash_addr_vld_ff,
  output logic [31:0]                flash_addr_ff,
  output logic                       irq
);
  import sfcs_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [AW-1:0]   aw_addr_ff;
  logic            aw_held_ff;
  logic [31:0]     w_data_ff;
  logic [3:0]      w_strb_ff;
  logic            w_held_ff;
  logic            bvalid_ff;
  logic [1:0]      bresp_ff;
  logic            rvalid_ff;
  logic [1:0]      rresp_ff;
  logic [31:0]     rdata_ff;
  logic            do_wr;
  logic            wr_hit_mapped;
  logic            rd_take;
  logic [31:0]     rd_word;
  logic            rd_mapped;
  logic            pol_ff;
  logic            pha_ff;
  logic            capt_ff;
  logic            exit_ff;
  logic            irq_mask_ff;
  logic            ofs_en_ff;
  logic            match_en_ff;
  logic            miss_en_ff;
  logic            hit_en_ff;
  logic [31:0]     shift_ff;
  logic [31:0]     target_ff;
  logic [31:0]     tally_ff [2];
  logic [1:0]      tally_inc;
  logic [1:0]      tally_clr;
  logic            exit_set;
  sfcs_link_cfg_t  link_cfg;

  // merge a write word into a register under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are parked independently; the write fires once both
  // are parked and the previous response is gone, so one write at a time
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign do_wr         = aw_held_ff & w_held_ff & ~bvalid_ff & clk_en;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      w_held_ff <= 1'b0;
      w_data_ff <= `SFCS_RST_WORD;
      w_strb_ff <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (do_wr) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr_ff[7:0])
      `SFCS_OFF_MODE, `SFCS_OFF_CAPT, `SFCS_OFF_STATUS, `SFCS_OFF_AUX,
      `SFCS_OFF_HIT, `SFCS_OFF_MISS, `SFCS_OFF_SHIFT, `SFCS_OFF_TARGET,
      `SFCS_OFF_IRQ_MASK: wr_hit_mapped = ((aw_addr_ff >> 8) == '0);
      default:            wr_hit_mapped = 1'b0;
    endcase
  end

  // response: slverr for unmapped addresses, held until bready
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SFCS_RESP_OKAY;
    end else if (clk_en) begin
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit_mapped ? `SFCS_RESP_OKAY : `SFCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // reserved bits are not stored, so they read back as zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_type_ff <= `SFCS_RST_CMD;
      pol_ff      <= `SFCS_RST_POL;
      pha_ff      <= `SFCS_RST_PHA;
      capt_ff     <= `SFCS_RST_CAPT;
      ofs_en_ff   <= 1'b0;
      match_en_ff <= 1'b0;
      miss_en_ff  <= 1'b0;
      hit_en_ff   <= 1'b0;
      irq_mask_ff <= 1'b0;
    end else if (do_wr && wr_hit_mapped) begin
      case (aw_addr_ff[7:0])
        `SFCS_OFF_MODE: begin
          if (w_strb_ff[0]) cmd_type_ff <= w_data_ff[`SFCS_POS_CMD_HI:`SFCS_POS_CMD_LO];
          if (w_strb_ff[1]) pol_ff <= w_data_ff[`SFCS_POS_POL];
          if (w_strb_ff[1]) pha_ff <= w_data_ff[`SFCS_POS_PHA];
        end
        `SFCS_OFF_CAPT: begin
          if (w_strb_ff[0]) capt_ff <= w_data_ff[`SFCS_POS_CAPT];
        end
        `SFCS_OFF_AUX: begin
          if (w_strb_ff[0]) begin
            ofs_en_ff   <= w_data_ff[`SFCS_POS_OFS_EN];
            match_en_ff <= w_data_ff[`SFCS_POS_MATCH_EN];
            miss_en_ff  <= w_data_ff[`SFCS_POS_MISS_EN];
            hit_en_ff   <= w_data_ff[`SFCS_POS_HIT_EN];
          end
        end
        `SFCS_OFF_IRQ_MASK: begin
          if (w_strb_ff[0]) irq_mask_ff <= w_data_ff[`SFCS_POS_EXIT];
        end
        default: begin
        end
      endcase
    end
  end

  // full-word registers take byte strobes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff  <= `SFCS_RST_WORD;
      target_ff <= `SFCS_RST_WORD;
    end else if (do_wr && wr_hit_mapped) begin
      if (aw_addr_ff[7:0] == `SFCS_OFF_SHIFT) shift_ff <= merge(shift_ff, w_data_ff, w_strb_ff);
      if (aw_addr_ff[7:0] == `SFCS_OFF_TARGET) target_ff <= merge(target_ff, w_data_ff, w_strb_ff);
    end
  end

  // ----------------------------------------------------------------
  // exit flag and interrupt
  // ----------------------------------------------------------------
  // a finish in the clearing cycle is kept: the set beats the clear
  assign exit_set = xfer_done & ((cmd_type_ff == `SFCS_CMD_EXIT_A) |
                                 (cmd_type_ff == `SFCS_CMD_EXIT_B));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      exit_ff <= 1'b0;
    end else if (clk_en) begin
      if (exit_set) begin
        exit_ff <= 1'b1;
      end else if (do_wr && aw_addr_ff[7:0] == `SFCS_OFF_STATUS && wr_hit_mapped &&
                   w_strb_ff[0] && w_data_ff[`SFCS_POS_EXIT]) begin
        exit_ff <= 1'b0;
      end
    end
  end

  // level output, dropped by clearing the status bit or the irq mask bit
  assign irq = exit_ff & irq_mask_ff;

  // ----------------------------------------------------------------
  // hit and miss tallies
  // ----------------------------------------------------------------
  assign tally_inc[0] = lookup.valid & lookup.hit & hit_en_ff;
  assign tally_inc[1] = lookup.valid & ~lookup.hit & miss_en_ff &
                        (~match_en_ff | (lookup.addr == target_ff));
  assign tally_clr[0] = do_wr & wr_hit_mapped & (aw_addr_ff[7:0] == `SFCS_OFF_HIT);
  assign tally_clr[1] = do_wr & wr_hit_mapped & (aw_addr_ff[7:0] == `SFCS_OFF_MISS);

  // wrap is natural 32-bit overflow; a clear overrides a same-cycle step
  for (genvar i = 0; i < 2; i++) begin : g_tally
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        tally_ff[i] <= `SFCS_RST_WORD;
      end else if (clk_en) begin
        if (tally_clr[i]) begin
          tally_ff[i] <= `SFCS_RST_WORD;
        end else if (tally_inc[i]) begin
          tally_ff[i] <= tally_ff[i] + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // address shift
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_addr_vld_ff <= 1'b0;
      flash_addr_ff     <= `SFCS_RST_WORD;
    end else if (clk_en) begin
      flash_addr_vld_ff <= access.valid;
      if (access.valid) begin
        flash_addr_ff <= access.addr + (ofs_en_ff ? shift_ff : `SFCS_RST_WORD);
      end
    end
  end

  // ----------------------------------------------------------------
  // serial link capture
  // ----------------------------------------------------------------
  assign link_cfg.pol       = pol_ff;
  assign link_cfg.pha       = pha_ff;
  assign link_cfg.capt_edge = capt_ff;

  // idle level follows polarity; the clock generator outside drives the pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_idle_lvl_ff <= `SFCS_RST_POL;
    end else if (clk_en) begin
      sclk_idle_lvl_ff <= pol_ff;
    end
  end

  sfcs_capture u_capture (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .cfg        (link_cfg),
    .sclk_raw   (sclk_in),
    .sdi_raw    (sdi_in),
    .cap_pulse  (cap_pulse),
    .cap_bit_ff (cap_bit_ff)
  );

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // reads have no side effects; reserved bits return zero
  assign s_axi_arready = ~rvalid_ff;
  assign rd_take       = s_axi_arvalid & s_axi_arready & clk_en;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    rd_word   = `SFCS_RST_WORD;
    rd_mapped = ((s_axi_araddr >> 8) == '0);
    case (s_axi_araddr[7:0])
      `SFCS_OFF_MODE: begin
        rd_word[`SFCS_POS_CMD_HI:`SFCS_POS_CMD_LO] = cmd_type_ff;
        rd_word[`SFCS_POS_POL] = pol_ff;
        rd_word[`SFCS_POS_PHA] = pha_ff;
      end
      `SFCS_OFF_CAPT:     rd_word[`SFCS_POS_CAPT] = capt_ff;
      `SFCS_OFF_STATUS:   rd_word[`SFCS_POS_EXIT] = exit_ff;
      `SFCS_OFF_AUX: begin
        rd_word[`SFCS_POS_OFS_EN]   = ofs_en_ff;
        rd_word[`SFCS_POS_MATCH_EN] = match_en_ff;
        rd_word[`SFCS_POS_MISS_EN]  = miss_en_ff;
        rd_word[`SFCS_POS_HIT_EN]   = hit_en_ff;
      end
      `SFCS_OFF_HIT:      rd_word = tally_ff[0];
      `SFCS_OFF_MISS:     rd_word = tally_ff[1];
      `SFCS_OFF_SHIFT:    rd_word = shift_ff;
      `SFCS_OFF_TARGET:   rd_word = target_ff;
      `SFCS_OFF_IRQ_MASK: rd_word[`SFCS_POS_EXIT] = irq_mask_ff;
      default:            rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= `SFCS_RST_WORD;
      rresp_ff  <= `SFCS_RESP_OKAY;
    end else if (clk_en) begin
      if (rd_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mapped ? rd_word : `SFCS_RST_WORD;
        rresp_ff  <= rd_mapped ? `SFCS_RESP_OKAY : `SFCS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

endmodule // sfcs_top

// ===== verification/sfcs_monitor.sv
// port-level checks of the flash capture/stats block
module sfcs_monitor (
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  input wire logic                   clk_en,
  input wire logic                   s_axi_bvalid,
  input wire logic                   sclk_in,
  input wire logic                   sclk_idle_lvl_ff,
  input wire logic                   cap_pulse,
  input wire logic                   cap_bit_ff,
  input wire logic                   xfer_done,
  input wire sfcs_pkg::sfcs_access_t access,
  input wire logic [3:0]             cmd_type_ff,
  input wire logic                   flash_addr_vld_ff,
  input wire logic [31:0]            flash_addr_ff,
  input wire logic                   irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import sfcs_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ----
  // sequences
  // ----
  // irq up and no register write landing next cycle
  sequence s_irq_quiet;
    irq && clk_en ##1 !$rose(s_axi_bvalid);
  endsequence
  sequence s_cap_seen;
    cap_pulse ##1 1'h1;
  endsequence
  property p_irq_cause;
    $rose(irq) |-> $rose(s_axi_bvalid) || $past(xfer_done && cmd_type_ff[3:1] == 3'h6);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without exit or write");
  property p_irq_hold;
    s_irq_quiet |-> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a write");
  property p_idle;
    // idle level trails the polarity bit by one cycle, so the write answered a cycle earlier
    $changed(sclk_idle_lvl_ff) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
  endproperty
  a_idle: assert property (p_idle) else $error("idle level moved without a write");
  property p_cmd;
    $changed(cmd_type_ff) |-> $rose(s_axi_bvalid);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command type moved without a write");
  property p_cap_one;
    s_cap_seen |-> !cap_pulse;
  endproperty
  a_cap_one: assert property (p_cap_one) else $error("capture pulse longer than a cycle");
  // a synchronised edge takes two to three cycles to reach the pulse
  property p_cap_cause;
    cap_pulse |-> $past(sclk_in, 1) != $past(sclk_in, 2) || $past(sclk_in, 2) !=
      $past(sclk_in, 3) || $past(sclk_in, 3) != $past(sclk_in, 4);
  endproperty
  a_cap_cause: assert property (p_cap_cause) else $error("capture without clock edge");
  property p_capbit;
    $changed(cap_bit_ff) |-> $past(cap_pulse);
  endproperty
  a_capbit: assert property (p_capbit) else $error("captured bit moved without pulse");
  property p_addr_vld;
    clk_en |=> flash_addr_vld_ff == $past(access.valid);
  endproperty
  a_addr_vld: assert property (p_addr_vld) else $error("shifted address strobe wrong");
  property p_addr_hold;
    $changed(flash_addr_ff) |-> flash_addr_vld_ff;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without strobe");
endmodule // sfcs_monitor

// ===== verification/sfcs_flash_model.sv
// behavioural serial flash answering one byte per frame
module sfcs_flash_model (
  input  wire logic       go,
  input  wire logic       cpol,
  input  wire logic [7:0] dout,
  output logic            sclk,
  output logic            sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy = 1'h0;
  logic sck = 1'h0;
  initial sdo = 1'h0;
  // clock rests at its idle level outside frames
  assign sclk = busy ? sck : cpol;
  // msb first, next bit launched on the trailing edge, 80 ns per bit
  always @(posedge go) begin
    #3;
    sck = cpol;
    busy = 1'h1;
    for (int i = 7; i >= 0; i--) begin
      sdo = dout[i];
      #40 sck = !cpol;
      #40 sck = cpol;
    end
    sdo = !dout[0]; // released line must not look like a stale bit
    busy = 1'h0;
  end
endmodule // sfcs_flash_model

// ===== verification/test_serial_flash_capture_and_cache_stats.sv
// self-checking bench for the flash capture/stats block
module test_serial_flash_capture_and_cache_stats;
  timeunit 1ns;
  timeprecision 100ps;
  import sfcs_pkg::*;
  logic ref_clk, arst_n, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sclk, sdi, idle_lvl, cap_pulse, cap_bit;
  logic xfer_done, vld, irq, go, cpol, pol, pha, capt, rise, eb;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, rd, faddr;
  logic [1:0]   bresp, rresp, resp;
  sfcs_lookup_t lookup;
  sfcs_access_t access;
  int           num_errors, n_tests, n_pulse, p0;
  logic [7:0]   ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h30};
  logic [31:0]  rv [9] = '{32'h5, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  sfcs_top sfcs_top_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sclk_in(sclk), .sdi_in(sdi), .sclk_idle_lvl_ff(idle_lvl), .cap_pulse(cap_pulse),
    .cap_bit_ff(cap_bit), .xfer_done(xfer_done), .lookup(lookup), .access(access),
    .cmd_type_ff(), .flash_addr_vld_ff(vld), .flash_addr_ff(faddr), .irq(irq)
  );
  sfcs_flash_model sfcs_flash_model_i (
    .go(go), .cpol(cpol), .dout(8'ha5), .sclk(sclk), .sdo(sdi)
  );
  // ----
  // clock, pulse tally, watchdog
  // ----
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = !ref_clk;
  end
  always @(posedge ref_clk) if (cap_pulse) n_pulse++;
  // the whole run needs well under 5000 cycles
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // no cycle limit here: only the watchdog ends a wait for the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    resp = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    d = rdata;
    resp = rresp;
  endtask
  // one transfer finishing with the command type currently programmed
  task automatic pulse_done;
    @(posedge ref_clk);
    xfer_done <= 1'h1;
    @(posedge ref_clk);
    xfer_done <= 1'h0;
  endtask
  // n back-to-back lookups, one per cycle
  task automatic look(input logic h, input logic [31:0] a, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      lookup <= {1'h1, h, a};
    end
    @(posedge ref_clk);
    lookup <= '0;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd);
    chk(what, rd, exp);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, xfer_done, go, cpol} = '0;
    {awaddr, araddr, wdata, lookup, access} = '0;
    {arst_n, clk_en} = 2'h1;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      rd_chk("reset value", ra[i], rv[i]);
      chk("read resp", resp, 32'h0);
    end
    rd_chk("unmapped", 8'h40, 32'h0);
    chk("unmapped rresp", resp, 32'h2);
    axi_wr(8'h40, 32'h1);
    chk("unmapped bresp", resp, 32'h2);
    $display("reset test done");
    // every polarity, phase and capture select; a real frame each
    for (int k = 0; k < 8; k++) begin
      {capt, pha, pol} = k[2:0];
      axi_wr(8'h00, {16'h0, pha, pol, 14'h5});
      axi_wr(8'h04, {27'h0, capt, 4'h0});
      cpol <= pol;
      repeat (10) @(posedge ref_clk);
      rise = (capt && !pha) ? pol : (pol == pha);
      eb = (rise == !pol) ? 1'h1 : 1'h0;
      p0 = n_pulse;
      go <= 1'h1;
      @(posedge ref_clk);
      go <= 1'h0;
      repeat (80) @(posedge ref_clk);
      chk("capture count", n_pulse - p0, 32'h8);
      chk("captured bit", cap_bit, eb);
      chk("idle level", idle_lvl, pol);
    end
    $display("capture test done");
    axi_wr(8'h30, 32'h1);
    for (int c = 0; c < 16; c++) begin
      axi_wr(8'h00, c);
      pulse_done();
      eb = (c == 12 || c == 13);
      rd_chk("exit flag", 8'h08, eb);
      chk("irq", irq, eb);
      axi_wr(8'h08, 32'h0);
      rd_chk("flag after zero", 8'h08, eb);
      axi_wr(8'h08, 32'h1);
      rd_chk("flag after clear", 8'h08, 32'h0);
    end
    axi_wr(8'h30, 32'h0);
    axi_wr(8'h00, 32'hd);
    pulse_done();
    rd_chk("masked flag", 8'h08, 32'h1);
    chk("masked irq", irq, 32'h0);
    axi_wr(8'h30, 32'h1);
    rd_chk("flag held", 8'h08, 32'h1);
    chk("unmasked irq", irq, 32'h1);
    $display("exit flag test done");
    axi_wr(8'h1c, 32'h40);
    axi_wr(8'h0c, 32'h0);
    look(1'h1, 32'h40, 3);
    look(1'h0, 32'h40, 3);
    rd_chk("hits off", 8'h10, 32'h0);
    rd_chk("misses off", 8'h14, 32'h0);
    axi_wr(8'h0c, 32'h1);
    look(1'h1, 32'h80, 5);
    look(1'h0, 32'h40, 2);
    rd_chk("hits on", 8'h10, 32'h5);
    rd_chk("misses still off", 8'h14, 32'h0);
    // enable low freezes the tallies even with hits arriving
    clk_en <= 1'h0;
    look(1'h1, 32'h80, 3);
    clk_en <= 1'h1;
    rd_chk("hits frozen", 8'h10, 32'h5);
    axi_wr(8'h0c, 32'h2);
    look(1'h0, 32'h40, 2);
    look(1'h0, 32'h44, 3);
    look(1'h1, 32'h40, 2);
    rd_chk("misses on", 8'h14, 32'h5);
    rd_chk("hits held", 8'h10, 32'h5);
    axi_wr(8'h0c, 32'h6);
    look(1'h0, 32'h40, 2);
    look(1'h0, 32'h44, 3);
    rd_chk("matched misses", 8'h14, 32'h7);
    axi_wr(8'h10, 32'hffff_ffff);
    rd_chk("hits cleared", 8'h10, 32'h0);
    axi_wr(8'h14, 32'h0);
    rd_chk("misses cleared", 8'h14, 32'h0);
    $display("tally test done");
    axi_wr(8'h18, 32'h1000);
    rd_chk("shift value", 8'h18, 32'h1000);
    for (int e = 0; e < 2; e++) begin
      axi_wr(8'h0c, {28'h0, e[0], 3'h0});
      @(posedge ref_clk);
      access <= {1'h1, 32'h100};
      @(posedge ref_clk);
      access <= '0;
      #1;
      chk("address strobe", vld, 32'h1);
      chk("shifted address", faddr, e ? 32'h1100 : 32'h100);
    end
    $display("offset test done");
    report_and_stop();
  end
endmodule // test_serial_flash_capture_and_cache_stats

bind sfcs_top sfcs_monitor sfcs_monitor_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .s_axi_bvalid(s_axi_bvalid),
  .sclk_in(sclk_in), .sclk_idle_lvl_ff(sclk_idle_lvl_ff), .cap_pulse(cap_pulse),
  .cap_bit_ff(cap_bit_ff), .xfer_done(xfer_done), .access(access),
  .cmd_type_ff(cmd_type_ff), .flash_addr_vld_ff(flash_addr_vld_ff),
  .flash_addr_ff(flash_addr_ff), .irq(irq)
);
